/* rtl/icd_pkg.sv */
package icd_pkg;

   // depth of the pin synchroniser
   localparam int unsigned SYNC_STAGES = 3;

   // level seen on the divide-select pin when nothing drives it
   localparam logic SELECT_PULL_LEVEL = 1'b0;

   // divide factors that the select pin chooses between
   localparam int unsigned DIV_FACTOR_HIGH = 1;
   localparam int unsigned DIV_FACTOR_LOW = 2;

   // settling time of the loop in divide-by-one mode, in input clock cycles
   localparam int unsigned LOOP_LOCK_CYCLES = 10000;
   localparam int unsigned LOCK_CNT_W = 14;

   // least reset hold that board logic must give, in input clock cycles
   localparam int unsigned RESET_HOLD_DIV2_CYCLES = 32;
   localparam int unsigned RESET_HOLD_DIV1_CYCLES = 10000;

   // values after reset
   localparam logic RESET_PHASE = 1'b0;
   localparam logic RESET_TICK = 1'b0;
   localparam logic RESET_SELECT = 1'b0;

   typedef enum logic [1:0] {
      ICD_ST_DIV2,
      ICD_ST_LOOP_LOCK,
      ICD_ST_DIV1
   } icd_state_t;

endpackage : icd_pkg

/* rtl/icd_select_sync.sv */
`timescale 1ns/100ps
module icd_select_sync (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic raw_in,
   output logic level_out
);
   import icd_pkg::*;

   logic [SYNC_STAGES-1:0] stage_q;
   logic [SYNC_STAGES-1:0] stage_d;
   logic level_q;
   logic level_d;

   // stage 0 only feeds stage 1; the level moves once stages 1 and 2 agree
   always_comb begin
      stage_d = {stage_q[SYNC_STAGES-2:0], raw_in};
      level_d = level_q;
      if (stage_q[1] == stage_q[2]) begin
         level_d = stage_q[2];
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage_q <= '0;
         level_q <= RESET_SELECT;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
      end
   end

   assign level_out = level_q;

endmodule : icd_select_sync

/* rtl/icd_clock_divider.sv */
`timescale 1ns/100ps
module icd_clock_divider #(
   parameter int unsigned LOCK_CYCLES = icd_pkg::LOOP_LOCK_CYCLES
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic clock_divide_select_in,
   input wire logic clock_divide_select_driven_in,
   output logic internal_clock_en_out,
   output logic [1:0] processor_clock_outputs_out,
   output logic divide_by_one_out,
   output logic loop_locked_out
);
   import icd_pkg::*;

   // the lock counter cannot serve a count of zero or one past its width
   if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << LOCK_CNT_W)) begin : g_bad_lock
      $error("LOCK_CYCLES out of range for the lock counter");
   end

   localparam logic [LOCK_CNT_W-1:0] LOCK_LAST =
      LOCK_CNT_W'(LOCK_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // select pin

   logic select_raw;
   logic mode_one;

   // a floating pin reads as the weak pull level
   assign select_raw = clock_divide_select_driven_in ?
                       clock_divide_select_in : SELECT_PULL_LEVEL;

   icd_select_sync u_select_sync (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .raw_in(select_raw),
      .level_out(mode_one)
   );

   ////////////////////////////////////////////////////////////////////////////
   // divider and loop model

   icd_state_t state_q;
   icd_state_t state_d;
   logic phase_q;
   logic phase_d;
   logic [LOCK_CNT_W-1:0] lock_cnt_q;
   logic [LOCK_CNT_W-1:0] lock_cnt_d;
   logic tick_q;
   logic tick_d;

   // the mode is re-evaluated every cycle, so a moving pin moves the clock
   always_comb begin
      state_d = state_q;
      phase_d = phase_q;
      lock_cnt_d = lock_cnt_q;
      tick_d = 1'b0;
      case (state_q)
         ICD_ST_DIV2: begin
            phase_d = ~phase_q;
            tick_d = phase_q;
            if (mode_one) begin
               state_d = ICD_ST_LOOP_LOCK;
               lock_cnt_d = '0;
            end
         end
         ICD_ST_LOOP_LOCK: begin
            // no ticks while the loop settles; a glitchy clock is worse
            lock_cnt_d = lock_cnt_q + 1'b1;
            if (!mode_one) begin
               state_d = ICD_ST_DIV2;
               phase_d = RESET_PHASE;
            end else if (lock_cnt_q == LOCK_LAST) begin
               state_d = ICD_ST_DIV1;
            end
         end
         ICD_ST_DIV1: begin
            tick_d = 1'b1;
            if (!mode_one) begin
               state_d = ICD_ST_DIV2;
               phase_d = RESET_PHASE;
            end
         end
         default: begin
            state_d = ICD_ST_DIV2;
            phase_d = RESET_PHASE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= ICD_ST_DIV2;
         phase_q <= RESET_PHASE;
         lock_cnt_q <= '0;
         tick_q <= RESET_TICK;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         lock_cnt_q <= lock_cnt_d;
         tick_q <= tick_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // the tick is the one reference every launch and sample is timed on
   assign internal_clock_en_out = tick_q;
   assign processor_clock_outputs_out = {tick_q, tick_q};
   assign divide_by_one_out = (state_q == ICD_ST_DIV1);
   assign loop_locked_out = (state_q == ICD_ST_DIV1);

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_div2_twice;
      (state_q == ICD_ST_DIV2) ##1 (state_q == ICD_ST_DIV2);
   endsequence

   property p_div2_alternates;
      @(posedge sys_clk_in) disable iff (rst_in)
      s_div2_twice |=> (internal_clock_en_out != $past(internal_clock_en_out));
   endproperty
   a_div2_alternates: assert property (p_div2_alternates)
      else $error("divide-by-two tick does not alternate");

   property p_div1_every_cycle;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_q == ICD_ST_DIV1) |=> internal_clock_en_out;
   endproperty
   a_div1_every_cycle: assert property (p_div1_every_cycle)
      else $error("divide-by-one mode missed a tick");

   property p_pins_identical;
      @(posedge sys_clk_in) disable iff (rst_in)
      processor_clock_outputs_out[0] == processor_clock_outputs_out[1];
   endproperty
   a_pins_identical: assert property (p_pins_identical)
      else $error("output clock pins differ");

   property p_pins_follow_internal;
      @(posedge sys_clk_in) disable iff (rst_in)
      processor_clock_outputs_out[0] == internal_clock_en_out;
   endproperty
   a_pins_follow_internal: assert property (p_pins_follow_internal)
      else $error("output clock differs from internal clock");

   property p_floating_pulls_low;
      @(posedge sys_clk_in) disable iff (rst_in)
      (!clock_divide_select_driven_in) [*5] |-> !mode_one;
   endproperty
   a_floating_pulls_low: assert property (p_floating_pulls_low)
      else $error("undriven select pin did not give divide-by-two");

   property p_rise_starts_lock;
      @(posedge sys_clk_in) disable iff (rst_in)
      (mode_one && state_q == ICD_ST_DIV2) |=>
         (state_q == ICD_ST_LOOP_LOCK && lock_cnt_q == '0);
   endproperty
   a_rise_starts_lock: assert property (p_rise_starts_lock)
      else $error("select high did not start the loop");

   property p_low_returns_div2;
      @(posedge sys_clk_in) disable iff (rst_in)
      (!mode_one && state_q != ICD_ST_DIV2) |=> (state_q == ICD_ST_DIV2);
   endproperty
   a_low_returns_div2: assert property (p_low_returns_div2)
      else $error("select low did not return to divide-by-two");

   property p_lock_silent;
      @(posedge sys_clk_in) disable iff (rst_in)
      (state_q == ICD_ST_LOOP_LOCK) |=> !internal_clock_en_out;
   endproperty
   a_lock_silent: assert property (p_lock_silent)
      else $error("tick issued while the loop settles");

   property p_lock_full_length;
      @(posedge sys_clk_in) disable iff (rst_in)
      $rose(state_q == ICD_ST_DIV1) |->
         ($past(state_q) == ICD_ST_LOOP_LOCK && $past(lock_cnt_q) == LOCK_LAST);
   endproperty
   a_lock_full_length: assert property (p_lock_full_length)
      else $error("divide-by-one entered before the loop settled");

   property p_div2_no_double;
      @(posedge sys_clk_in) disable iff (rst_in)
      (internal_clock_en_out && !divide_by_one_out &&
       $past(state_q) == ICD_ST_DIV2) |=> !internal_clock_en_out;
   endproperty
   a_div2_no_double: assert property (p_div2_no_double)
      else $error("two ticks in a row in divide-by-two mode");

endmodule : icd_clock_divider

/* test/icd_board_model.sv */
`timescale 1ns/100ps
module icd_board_model #(
   parameter int unsigned HOLD_DIV2 = 32,
   parameter int unsigned HOLD_DIV1 = 10000
) (
   input wire logic sys_clk_in,
   input wire logic div1_req_in,
   input wire logic float_req_in,
   output logic rst_out,
   output logic select_out,
   output logic driven_out
);
   int unsigned hold_cnt = 0;
   logic last_sel = 1'b0;
   initial begin
      rst_out = 1'b1;
      select_out = 1'b0;
      driven_out = 1'b1;
   end
   always @(negedge sys_clk_in) begin
      if (rst_out) begin
         hold_cnt <= hold_cnt + 1;
         if (hold_cnt + 1 >= (div1_req_in ? HOLD_DIV1 : HOLD_DIV2)) begin
            rst_out <= 1'b0;
         end
      end
      // a released line shows the inverse of its last level, not a tidy one
      if (float_req_in) begin
         driven_out <= 1'b0;
         select_out <= ~last_sel;
      end else begin
         driven_out <= 1'b1;
         select_out <= div1_req_in;
         last_sel <= div1_req_in;
      end
   end
endmodule : icd_board_model

/* test/input_clock_divider_test.sv */
`timescale 1ns/100ps
module input_clock_divider_test;
   import icd_pkg::*;
   localparam int unsigned LOCK_SIM = 8;
   logic sys_clk_in = 1'b0;
   logic rst_in, sel, driven, en, div1, locked;
   logic div1_req = 1'b0;
   logic float_req = 1'b0;
   logic [1:0] pclk;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   always #50 sys_clk_in = ~sys_clk_in;
   icd_board_model u_board (.sys_clk_in(sys_clk_in), .div1_req_in(div1_req),
      .float_req_in(float_req), .rst_out(rst_in), .select_out(sel),
      .driven_out(driven));
   icd_clock_divider #(.LOCK_CYCLES(LOCK_SIM)) u_dut (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .clock_divide_select_in(sel), .clock_divide_select_driven_in(driven),
      .internal_clock_en_out(en), .processor_clock_outputs_out(pclk),
      .divide_by_one_out(div1), .loop_locked_out(locked));
   task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   // every sample flips and both pins follow the enable
   task automatic check_div2(int n);
      logic prev;
      @(negedge sys_clk_in);
      prev = en;
      repeat (n) begin
         @(negedge sys_clk_in);
         check("toggle", {1'b0, en}, {1'b0, ~prev});
         check("pins", pclk, {en, en});
         check("mode", {div1, locked}, 2'h0);
         prev = en;
      end
   endtask : check_div2
   task automatic test_walk();
      wait (rst_in === 1'b0);
      for (int i = 0; i < 6; i++) begin
         @(negedge sys_clk_in);
         check("walk", pclk, {2{i[0]}});
      end
      $display("test walk done");
   endtask : test_walk
   task automatic test_div1();
      int k;
      // non-blocking, so the board model samples the request one edge later
      div1_req <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(negedge sys_clk_in);
         if (div1 === 1'b1) break;
         if (k >= 6 && k <= 11) check("lock quiet", {1'b0, en}, 2'h0);
      end
      check("lock wait", {1'b0, k >= LOCK_SIM + 1 && k <= LOCK_SIM + 8},
         2'h1);
      repeat (6) begin
         @(negedge sys_clk_in);
         check("div1", pclk, 2'h3);
         check("locked", {en, locked}, 2'h3);
      end
      $display("test div1 done");
   endtask : test_div1
   task automatic test_back();
      div1_req <= 1'b0;
      repeat (8) @(negedge sys_clk_in);
      check("back", {1'b0, div1}, 2'h0);
      check_div2(6);
      $display("test back done");
   endtask : test_back
   task automatic test_float();
      // the released line shows high, so a missing pull would reach div1
      float_req <= 1'b1;
      repeat (16) begin
         @(negedge sys_clk_in);
         check("float", {1'b0, div1}, 2'h0);
      end
      check_div2(6);
      $display("test float done");
   endtask : test_float
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles >= 2000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      test_walk();
      test_div1();
      test_back();
      test_float();
      finish_test();
   end
endmodule : input_clock_divider_test
